// file: neutral_source.sv
`timescale 1ns/1ps
`default_nettype none
// neutral current measurement: one strobed sample every second clock
module neutral_source (
  input wire logic clk,
  input wire logic [15:0] level,
  output var resid_pkg::sample_type sample
);
  logic tgl = 1'b0; // strobe phase
  // off-strobe value is inverted so only strobed values can count
  always @(posedge clk) begin
    tgl <= !tgl;
    sample.valid <= tgl;
    sample.value <= tgl ? level : ~level;
  end
endmodule
`default_nettype wire

// file: resid_pkg.sv
// Notes on behaviour
// RULE_01 - pick up above 1.05 times setting
// RULE_02 - release at 1 times setting
// RULE_03 - trip after pickup held for delay
// RULE_04 - any overcurrent pickup disables the element
// RULE_05 - measure the neutral current input
// RULE_06 - enable input defaults to one
// RULE_07 - enable from contact or command
// RULE_08 - pickup also means timer running
// RULE_09 - masked trip is trip gated by mask
// RULE_10 - status shows enabled or disabled
// RULE_11 - drop or disable clears timer and outputs
package resid_pkg;
  // clock rate and the delay timer's base tick
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  // thresholds as ratios in hundredths
  localparam int PICKUP_NUM = 105;
  localparam int RELEASE_NUM = 100;
  // averaging depth of the mean filter, as a shift
  localparam int MEAN_SHIFT = 3;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PICKUP_OFFSET = 8'h04;
  localparam logic [7:0] DELAY_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] MEAN_OFFSET = 8'h10;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h14;
  localparam logic [7:0] INT_CLEAR_OFFSET = 8'h18;
  localparam logic [7:0] INT_ENABLE_OFFSET = 8'h1c;
  // reset values
  localparam logic [3:0] CTRL_RESET = 4'he;
  localparam logic [15:0] PICKUP_RESET = 16'h0064;
  localparam logic [15:0] DELAY_RESET = 16'h0005;
  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;
  // control register layout, bit 0 at the right
  typedef struct packed {
    logic cmd_enable;
    logic src_cmd;
    logic trip_mask;
    logic elem_on;
  } ctrl_type;
  // one neutral current sample
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } sample_type;
  // pickups of the overcurrent elements
  typedef struct packed {
    logic gnd_time;
    logic gnd_inst;
    logic ph_time;
    logic ph_inst;
  } oc_pickup_type;
  // element sequence
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TIMING = 2'b01,
    ST_TRIPPED = 2'b10
  } elem_state_type;
endpackage

// file: resid_sva.sv
`timescale 1ns/1ps
`default_nettype none
// relates the pickup, trip and masked trip outputs to their causes
module resid_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic pready,
  input wire resid_pkg::oc_pickup_type oc_pickup,
  input wire logic resid_pickup,
  input wire logic resid_trip,
  input wire logic resid_trip_masked,
  input wire logic resid_enabled_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_trip_needs_pickup: assert property (resid_trip |-> resid_pickup)
    else $error("trip without pickup");
  chk_oc_blocks_element: assert property (oc_pickup != '0 |=> !resid_pickup && !resid_trip)
    else $error("element active during overcurrent pickup");
  chk_trip_after_pickup: assert property ($rose(resid_trip) |-> $past(resid_pickup))
    else $error("trip rose without prior pickup");
  chk_pickup_rise_clean: assert property ($rose(resid_pickup) |-> !resid_trip)
    else $error("trip with no delay");
  chk_drop_clears_trip: assert property ($fell(resid_pickup) |-> !resid_trip)
    else $error("trip held after drop");
  chk_disabled_quiet: assert property (!resid_enabled_status |-> !resid_pickup && !resid_trip)
    else $error("output while disabled");
  chk_masked_gated: assert property (resid_trip_masked |-> resid_trip)
    else $error("masked trip without trip");
  // zero wait states are part of the bus contract
  chk_bus_ready: assert property (psel |-> pready)
    else $error("pready low");
endmodule
`default_nettype wire

// file: residual_current_element.sv
`timescale 1ns/1ps
`default_nettype none
module residual_current_element #(
  parameter int TICK_CYCLES = resid_pkg::TICK_CYCLES,
  parameter int VALUE_WIDTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // neutral current samples, same clock domain
  input wire resid_pkg::sample_type neutral_sample,
  // overcurrent element pickups, same clock domain
  input wire resid_pkg::oc_pickup_type oc_pickup,
  // enable contact, asynchronous pin
  input wire logic resid_enable_in,
  // relay outputs
  output logic resid_pickup,
  output logic resid_trip,
  output logic resid_trip_masked,
  output logic resid_enabled_status,
  output logic irq
);

  // accumulator holds the mean times the filter depth
  localparam int ACC_WIDTH = VALUE_WIDTH + resid_pkg::MEAN_SHIFT;
  // eight spare bits hold a numerator of up to 255 hundredths
  localparam int PROD_WIDTH = VALUE_WIDTH + 8;
  // prescaler wide enough for a whole tick
  localparam int TICK_WIDTH = $clog2(TICK_CYCLES + 1);

  // settings written over the bus
  resid_pkg::ctrl_type ctrl; // element controls
  logic [15:0] pickup_set; // pickup threshold, current units
  logic [15:0] delay_set; // delay in timer ticks
  logic [3:0] int_status; // sticky events
  logic [3:0] int_enable; // event mask
  // measurement and enable path
  logic [ACC_WIDTH-1:0] mean_acc; // filter accumulator
  logic [VALUE_WIDTH-1:0] mean; // mean neutral current
  logic [1:0] enable_sync; // contact synchroniser
  logic enable_src; // selected enable source
  logic active; // element in service
  logic above_pickup; // mean over pickup level
  logic at_release; // mean at or below release level
  // both sides of each comparison in hundredths
  logic [PROD_WIDTH-1:0] mean_scaled;
  logic [PROD_WIDTH-1:0] pickup_scaled;
  logic [PROD_WIDTH-1:0] release_scaled;
  // sequence and delay timer
  resid_pkg::elem_state_type state;
  resid_pkg::elem_state_type next_state;
  logic [TICK_WIDTH-1:0] tick_count; // cycles within a tick
  logic tick; // one timer tick elapsed
  logic [15:0] elapsed; // ticks since pickup
  // interrupt and bus helpers
  logic [3:0] events; // one-cycle event pulses
  logic wr_en; // apb write at access edge
  logic rd_setup; // apb read in setup phase
  logic mapped; // address hits a register

  // contact pin passes two flops; only the second is read
  // both stages start high so the enable reads as on out of reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_sync <= 2'b11;
    end else begin
      enable_sync <= {enable_sync[0], resid_enable_in};
    end
  end

  // contact level or panel command drives the enable [RULE_07]
  // command source and value reset to one, so enable defaults on [RULE_06]
  assign enable_src = ctrl.src_cmd ? ctrl.cmd_enable : enable_sync[1];

  // any overcurrent pickup takes the element out of service [RULE_04]
  assign active = ctrl.elem_on & enable_src & ~(|oc_pickup);

  // running mean of the neutral input samples [RULE_05]
  // a single spike moves the mean by only an eighth of its size
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mean_acc <= '0;
    end else if (neutral_sample.valid) begin
      mean_acc <= mean_acc - (mean_acc >> resid_pkg::MEAN_SHIFT)
                  + ACC_WIDTH'(neutral_sample.value);
    end
  end

  // the integer part of the accumulator is the mean
  assign mean = mean_acc[ACC_WIDTH-1:resid_pkg::MEAN_SHIFT];

  // compare in hundredths to keep the ratios exact
  assign mean_scaled = PROD_WIDTH'(mean) * PROD_WIDTH'(resid_pkg::RELEASE_NUM);
  assign pickup_scaled = PROD_WIDTH'(pickup_set) * PROD_WIDTH'(resid_pkg::PICKUP_NUM);
  assign release_scaled = PROD_WIDTH'(pickup_set) * PROD_WIDTH'(resid_pkg::RELEASE_NUM);
  assign above_pickup = mean_scaled > pickup_scaled; // [RULE_01]
  // equality at the release level already counts as released
  assign at_release = mean_scaled <= release_scaled; // [RULE_02]

  // tick prescaler restarts with each pickup so timing starts clean
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_count <= '0;
    end else if (state != resid_pkg::ST_TIMING || tick) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + TICK_WIDTH'(1);
    end
  end

  // one tick every TICK_CYCLES clocks, only while timing
  assign tick = tick_count == TICK_WIDTH'(TICK_CYCLES - 1);

  // elapsed ticks while picked up; cleared on drop or disable [RULE_11]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      elapsed <= '0;
    end else if (next_state == resid_pkg::ST_IDLE) begin
      elapsed <= '0;
    end else if (tick && elapsed != 16'hffff) begin
      elapsed <= elapsed + 16'h0001;
    end
  end

  // element sequence
  // idle waits for the pickup level, timing counts ticks, tripped holds
  // leaving service always returns to idle in a single step
  always_comb begin
    next_state = state;
    case (state)
      resid_pkg::ST_IDLE: begin
        // wait for the mean to pass the pickup level
        if (active && above_pickup) begin
          next_state = resid_pkg::ST_TIMING; // [RULE_01]
        end
      end
      resid_pkg::ST_TIMING: begin
        // a drop or loss of service restarts the whole delay
        if (!active || at_release) begin
          next_state = resid_pkg::ST_IDLE; // [RULE_02] [RULE_11]
        end else if (elapsed >= delay_set) begin
          next_state = resid_pkg::ST_TRIPPED; // [RULE_03]
        end
      end
      resid_pkg::ST_TRIPPED: begin
        // trip stands only while the condition stands
        if (!active || at_release) begin
          next_state = resid_pkg::ST_IDLE; // [RULE_11]
        end
      end
      default: begin
        // unused code recovers to idle
        next_state = resid_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= resid_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // outputs from flops; pickup covers timing and tripped [RULE_08]
  // pickup, trip and masked trip follow next_state, so they change on the same edge; enabled status follows active
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resid_pickup <= 1'b0;
      resid_trip <= 1'b0;
      resid_trip_masked <= 1'b0;
      resid_enabled_status <= 1'b0;
    end else begin
      resid_pickup <= next_state != resid_pkg::ST_IDLE; // [RULE_08]
      resid_trip <= next_state == resid_pkg::ST_TRIPPED; // [RULE_03]
      resid_trip_masked <= (next_state == resid_pkg::ST_TRIPPED) & ctrl.trip_mask; // [RULE_09]
      resid_enabled_status <= active; // [RULE_10]
    end
  end

  // events: pickup rise, trip rise, pickup drop, enable change
  // each bit is a single-cycle pulse; the sticky register keeps it
  assign events = {
    active != resid_enabled_status,
    resid_pickup & (next_state == resid_pkg::ST_IDLE),
    (next_state == resid_pkg::ST_TRIPPED) & ~resid_trip,
    (next_state != resid_pkg::ST_IDLE) & ~resid_pickup
  };

  // apb decode; zero wait states
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  // every mapped offset, whatever its direction
  // a read of a write-only word returns zero rather than an error
  always_comb begin
    case (paddr)
      resid_pkg::CTRL_OFFSET,
      resid_pkg::PICKUP_OFFSET,
      resid_pkg::DELAY_OFFSET,
      resid_pkg::STATUS_OFFSET,
      resid_pkg::MEAN_OFFSET,
      resid_pkg::INT_STATUS_OFFSET,
      resid_pkg::INT_CLEAR_OFFSET,
      resid_pkg::INT_ENABLE_OFFSET: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
  // unmapped access errors during the access phase only
  assign pslverr = psel & penable & ~mapped;

  // software settings
  // reserved bits of each word are dropped on write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= resid_pkg::CTRL_RESET;
      pickup_set <= resid_pkg::PICKUP_RESET;
      delay_set <= resid_pkg::DELAY_RESET;
      int_enable <= resid_pkg::INT_ENABLE_RESET;
    end else if (wr_en) begin
      case (paddr)
        resid_pkg::CTRL_OFFSET: begin
          ctrl <= pwdata[3:0];
        end
        resid_pkg::PICKUP_OFFSET: begin
          pickup_set <= pwdata[15:0];
        end
        resid_pkg::DELAY_OFFSET: begin
          delay_set <= pwdata[15:0];
        end
        resid_pkg::INT_ENABLE_OFFSET: begin
          int_enable <= pwdata[3:0];
        end
        default: begin
          // read-only and clear offsets leave the settings alone
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_status <= '0;
    end else if (wr_en && paddr == resid_pkg::INT_CLEAR_OFFSET) begin
      int_status <= (int_status & ~pwdata[3:0]) | events;
    end else begin
      int_status <= int_status | events;
    end
  end

  // interrupt level from enabled sticky bits
  // registered, so it trails the sticky bits by one clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end

  // read data is captured in the setup phase
  // the clear register and unmapped offsets read back zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        resid_pkg::CTRL_OFFSET: prdata <= {28'h0000000, ctrl};
        resid_pkg::PICKUP_OFFSET: prdata <= {16'h0000, pickup_set};
        resid_pkg::DELAY_OFFSET: prdata <= {16'h0000, delay_set};
        resid_pkg::STATUS_OFFSET: begin
          prdata <= {28'h0000000, resid_enabled_status, resid_trip_masked, resid_trip, resid_pickup};
        end
        resid_pkg::MEAN_OFFSET: prdata <= 32'(mean);
        resid_pkg::INT_STATUS_OFFSET: prdata <= {28'h0000000, int_status};
        resid_pkg::INT_ENABLE_OFFSET: prdata <= {28'h0000000, int_enable};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: test_residual_current_element.sv
`timescale 1ns/1ps
`default_nettype none
module test_residual_current_element;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic rd_err; // pslverr seen at the pready edge
  logic pready, pslverr, irq;
  logic [15:0] level = 16'h0; // neutral current fed to the source model
  resid_pkg::sample_type neutral_sample;
  resid_pkg::oc_pickup_type oc_pickup = '0;
  logic resid_enable_in = 1'b0;
  logic resid_pickup, resid_trip, resid_trip_masked, resid_enabled_status;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  initial forever #12.5 clk = ~clk;
  // short tick so delays fit in the run
  residual_current_element #(.TICK_CYCLES(4)) residual_current_element_inst (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .neutral_sample(neutral_sample), .oc_pickup(oc_pickup),
    .resid_enable_in(resid_enable_in), .resid_pickup(resid_pickup), .resid_trip(resid_trip),
    .resid_trip_masked(resid_trip_masked), .resid_enabled_status(resid_enabled_status), .irq(irq));
  neutral_source neutral_source_inst (.clk(clk), .level(level), .sample(neutral_sample));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; read data taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // {irq, enabled, masked, trip, pickup} under a mask, looked at once settled
  task automatic outs(input logic [4:0] e, input logic [4:0] m = 5'h1f);
    #1;
    check(32'({irq, resid_enabled_status, resid_trip_masked, resid_trip, resid_pickup} & m), 32'(e & m));
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    cyc(8);
    arst_n <= 1'b1;
    rdchk(8'h00, 32'he);
    check(32'(rd_err), 32'h0);
    rdchk(8'h04, 32'h64);
    rdchk(8'h08, 32'h5);
    rdchk(8'h20, 32'h0);
    check(32'(rd_err), 32'h1);
    apb(1'b1, 8'h08, 32'd200);
    apb(1'b1, 8'h1c, 32'h1);
    apb(1'b1, 8'h00, 32'hf);
    level <= 16'd103;
    cyc(400);
    outs(5'h08);
    level <= 16'd106;
    cyc(300);
    outs(5'h19);
    cyc(700);
    outs(5'h1f);
    rdchk(8'h0c, 32'hf);
    rdchk(8'h14, 32'hb);
    apb(1'b1, 8'h18, 32'hf);
    apb(1'b1, 8'h00, 32'hd);
    cyc(2);
    outs(5'h0b);
    apb(1'b1, 8'h00, 32'hf);
    level <= 16'd103;
    cyc(400);
    outs(5'h0f);
    level <= 16'd100;
    cyc(400);
    outs(5'h08);
    apb(1'b1, 8'h08, 32'd2);
    level <= 16'd106;
    cyc(300);
    outs(5'h03, 5'h03);
    for (int i = 0; i < 4; i++) begin
      oc_pickup <= 4'h1 << i;
      cyc(3);
      outs(5'h00, 5'h03);
      oc_pickup <= '0;
      cyc(3);
      outs(5'h01, 5'h03);
      cyc(30);
    end
    apb(1'b1, 8'h00, 32'h7);
    cyc(2);
    outs(5'h00, 5'h0f);
    apb(1'b1, 8'h00, 32'h3);
    cyc(2);
    outs(5'h00, 5'h0f);
    resid_enable_in <= 1'b1;
    cyc(6);
    outs(5'h08, 5'h08);
    summarize();
  end
endmodule
bind residual_current_element resid_sva resid_sva_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
  .pready(pready), .oc_pickup(oc_pickup), .resid_pickup(resid_pickup), .resid_trip(resid_trip),
  .resid_trip_masked(resid_trip_masked), .resid_enabled_status(resid_enabled_status));
`default_nettype wire
